// >>> fwd_consts.svh
// Constants for the firmware download handler
`ifndef FWD_CONSTS_SVH
`define FWD_CONSTS_SVH
`define FWD_OPCODE_DMA     8'h93
`define FWD_SUB_OFS_SAVE   8'h03
`define FWD_SUB_SAVE       8'h07
`define FWD_SUB_OFS_DEFER  8'h0E
`define FWD_SUB_ACTIVATE   8'h0F
`define FWD_SECTOR_SHIFT   7
`define FWD_ADDR_W         23
`define FWD_ERR_ABORT      8'h04
`define FWD_ERR_RELOAD     8'h40
`define FWD_STAT_OK        8'h50
`define FWD_STAT_ERR       8'h51
`define FWD_HDR_TOTAL_MSB  15
`define FWD_HDR_RELOAD_BIT 16
`define FWD_REG_CMD        8'h00
`define FWD_REG_OFFSET     8'h04
`define FWD_REG_COUNT      8'h08
`define FWD_REG_DATA       8'h0C
`define FWD_REG_STATUS     8'h10
`endif

// >>> fwd_pkg.sv
// Types for the firmware download handler
package fwd_pkg;
  typedef enum logic [1:0] {
    FWD_IDLE   = 2'b00,
    FWD_DATA   = 2'b01,
    FWD_VERIFY = 2'b10
  } fwd_state_t;

  typedef struct packed {
    fwd_state_t  state;
    logic        cmd_ready;
    logic        dma_ready;
    logic        done;
    logic [7:0]  err;
    logic [7:0]  stat;
    logic [7:0]  feat;
    logic [22:0] words;
    logic [22:0] waddr;
    logic [15:0] expect_ofs;
    logic [15:0] total;
    logic        reload_req;
    logic        pending;
    logic        wr_valid;
    logic [22:0] wr_addr;
    logic [31:0] wr_data;
    logic        commit;
    logic        activate;
    logic        spin_down;
    logic        discard;
  } fwd_dev_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        pushed;
    logic        cmd_valid;
    logic [7:0]  opcode;
    logic [7:0]  feature;
    logic [15:0] count;
    logic [15:0] offset;
    logic        dma_valid;
    logic [31:0] dma_data;
    logic        done_seen;
    logic        busy;
    logic [7:0]  err;
    logic [7:0]  stat;
  } fwd_host_t;
endpackage : fwd_pkg

// >>> fwd_if.sv
// Link between host controller and download handler
`timescale 1ns/1ps
interface fwd_if;
  // Command block
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_opcode;
  logic [7:0]  cmd_feature;
  logic [7:0]  cmd_seccnt;
  logic [7:0]  cmd_secnum;
  logic [7:0]  cmd_cyl_lo;
  logic [7:0]  cmd_cyl_hi;
  // Data phase
  logic        dma_valid;
  logic        dma_ready;
  logic [31:0] dma_data;
  // Completion
  logic        done;
  logic [7:0]  err_reg;
  logic [7:0]  stat_reg;

  modport dev (input cmd_valid, cmd_opcode, cmd_feature, cmd_seccnt, cmd_secnum, cmd_cyl_lo, cmd_cyl_hi,
               output cmd_ready, input dma_valid, dma_data, output dma_ready, output done, err_reg, stat_reg);
  modport host (output cmd_valid, cmd_opcode, cmd_feature, cmd_seccnt, cmd_secnum, cmd_cyl_lo, cmd_cyl_hi,
                input cmd_ready, output dma_valid, dma_data, input dma_ready, input done, err_reg, stat_reg);
endinterface : fwd_if

// >>> fwd_host.sv
// Host controller end: APB registers driving download commands and data
`timescale 1ns/1ps
`include "fwd_consts.svh"
module fwd_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Link
  fwd_if.host              lnk
);
  fwd_pkg::fwd_host_t cur_ff;
  fwd_pkg::fwd_host_t nxt_cur;
  logic               access;
  logic               finish;

  assign access = psel && penable;
  assign finish = access && cur_ff.pready;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.pready = 1'b0;
    if (lnk.cmd_valid && lnk.cmd_ready) begin
      nxt_cur.cmd_valid = 1'b0;
      nxt_cur.busy = 1'b1;
    end
    if (lnk.dma_valid && lnk.dma_ready) begin
      nxt_cur.dma_valid = 1'b0;
    end
    if (lnk.done) begin
      nxt_cur.busy = 1'b0;
      nxt_cur.err = lnk.err_reg;
      nxt_cur.stat = lnk.stat_reg;
    end
    if (access && !cur_ff.pready) begin
      nxt_cur.pslverr = 1'b0;
      nxt_cur.prdata = 32'h0000_0000;
      if (paddr == `FWD_REG_DATA && pwrite) begin
        // Data word: four bytes, sectors are whole words
        if (!cur_ff.pushed) begin
          nxt_cur.dma_valid = 1'b1;
          nxt_cur.dma_data = pwdata;
          nxt_cur.pushed = 1'b1;
        end else if (lnk.dma_valid && lnk.dma_ready) begin
          nxt_cur.pready = 1'b1;
        end
      end else if (paddr == `FWD_REG_STATUS && !pwrite) begin
        nxt_cur.pready = 1'b1;
        nxt_cur.prdata = {8'h00, cur_ff.stat, cur_ff.err, 6'h00, cur_ff.done_seen,
                          cur_ff.busy || cur_ff.cmd_valid};
      end else if (paddr == `FWD_REG_CMD) begin
        nxt_cur.pready = 1'b1;
        nxt_cur.prdata = {16'h0000, cur_ff.opcode, cur_ff.feature};
      end else if (paddr == `FWD_REG_OFFSET) begin
        nxt_cur.pready = 1'b1;
        nxt_cur.prdata = {16'h0000, cur_ff.offset};
      end else if (paddr == `FWD_REG_COUNT) begin
        nxt_cur.pready = 1'b1;
        nxt_cur.prdata = {16'h0000, cur_ff.count};
      end else begin
        nxt_cur.pready = 1'b1;
        nxt_cur.pslverr = 1'b1;
      end
    end
    if (finish) begin
      nxt_cur.pushed = 1'b0;
      if (pwrite && !cur_ff.pslverr) begin
        if (paddr == `FWD_REG_CMD && !cur_ff.cmd_valid) begin
          // Opcode and subcommand issue the command
          nxt_cur.feature = pwdata[7:0];
          nxt_cur.opcode = pwdata[15:8];
          nxt_cur.cmd_valid = 1'b1;
        end else if (paddr == `FWD_REG_OFFSET) begin
          nxt_cur.offset = pwdata[15:0];
        end else if (paddr == `FWD_REG_COUNT) begin
          nxt_cur.count = pwdata[15:0];
        end
      end
      if (!pwrite && paddr == `FWD_REG_STATUS && !lnk.done) begin
        nxt_cur.done_seen = 1'b0;
      end
    end
    if (lnk.done) begin
      nxt_cur.done_seen = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pready = cur_ff.pready;
  assign prdata = cur_ff.prdata;
  assign pslverr = cur_ff.pslverr;
  assign lnk.cmd_valid = cur_ff.cmd_valid;
  assign lnk.cmd_opcode = cur_ff.opcode;
  assign lnk.cmd_feature = cur_ff.feature;
  assign lnk.cmd_seccnt = cur_ff.count[7:0];
  assign lnk.cmd_secnum = cur_ff.count[15:8];
  assign lnk.cmd_cyl_lo = cur_ff.offset[7:0];
  assign lnk.cmd_cyl_hi = cur_ff.offset[15:8];
  assign lnk.dma_valid = cur_ff.dma_valid;
  assign lnk.dma_data = cur_ff.dma_data;
endmodule : fwd_host

// >>> fwd_dev.sv
// Device end: firmware download command handler
// Notes on behaviour
// - Opcode 93h starts the DMA download
// - Subcommands 03h, 07h, 0Eh, 0Fh; rest reserved
// - Length is sector number high, count low
// - Host sends whole sectors only
// - Cylinder registers give segment start, 512-byte units
// - Offset used only for 03h and 0Eh
// - Host starts each image at offset zero
// - Out-of-sequence offset aborts, discards received segments
// - Host sends segments ascending without gaps
// - Saving subcommands activate image at once
// - Final segment triggers verification then storage
// - Deferred subcommand stores image without activating
// - Stored image activates only on 0Fh
// - Reset before final segment discards segments
// - Reset before activation discards stored image
// - Bad subcommand or security lock sets abort
// - Failed requested reload sets reload failure
// - Spin-up disabled means spin down after reload; 0Fh activation spins down even when no reload was requested
// - Zero length means no data transferred
`timescale 1ns/1ps
`include "fwd_consts.svh"
module fwd_dev (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Link
  fwd_if.dev               lnk,
  // Drive conditions
  input  wire logic        security_locked,
  input  wire logic        spinup_disabled,
  input  wire logic        reload_fail,
  // Image store
  output logic             img_wr_valid,
  output logic [22:0]      img_wr_addr,
  output logic [31:0]      img_wr_data,
  output logic             img_commit,
  output logic             img_discard,
  output logic             img_pending,
  // Firmware control
  output logic             fw_activate,
  output logic             spin_down
);
  fwd_pkg::fwd_dev_t cur_ff;
  fwd_pkg::fwd_dev_t nxt_cur;

  function automatic logic sub_valid(input logic [7:0] f);
    sub_valid = (f == `FWD_SUB_OFS_SAVE) || (f == `FWD_SUB_SAVE) ||
                (f == `FWD_SUB_OFS_DEFER) || (f == `FWD_SUB_ACTIVATE);
  endfunction : sub_valid

  function automatic logic [22:0] sec_to_words(input logic [15:0] s);
    sec_to_words = 23'(s) << `FWD_SECTOR_SHIFT;
  endfunction : sec_to_words

  logic [15:0] len_sec;
  logic [15:0] ofs_sec;
  logic [15:0] use_ofs;
  logic [15:0] tot;
  logic        take_cmd;
  logic        take_word;

  // Length and offset from the command block
  assign len_sec = {lnk.cmd_secnum, lnk.cmd_seccnt};
  assign ofs_sec = {lnk.cmd_cyl_hi, lnk.cmd_cyl_lo};
  // Offset ignored for single-transfer save
  assign use_ofs = (lnk.cmd_feature == `FWD_SUB_SAVE) ? 16'h0000 : ofs_sec;
  assign take_cmd = lnk.cmd_valid && cur_ff.cmd_ready;
  assign take_word = lnk.dma_valid && cur_ff.dma_ready;
  // Image header sits in the first word of offset zero
  assign tot = (cur_ff.waddr == 23'h000000) ? lnk.dma_data[`FWD_HDR_TOTAL_MSB:0] : cur_ff.total;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.wr_valid = 1'b0;
    nxt_cur.commit = 1'b0;
    nxt_cur.activate = 1'b0;
    nxt_cur.spin_down = 1'b0;
    nxt_cur.discard = 1'b0;
    case (cur_ff.state)
      fwd_pkg::FWD_IDLE: begin
        nxt_cur.cmd_ready = 1'b1;
        if (take_cmd) begin
          nxt_cur.feat = lnk.cmd_feature;
          nxt_cur.err = 8'h00;
          nxt_cur.stat = `FWD_STAT_OK;
          if (lnk.cmd_opcode != `FWD_OPCODE_DMA || !sub_valid(lnk.cmd_feature) ||
              security_locked) begin
            // Wrong opcode, reserved code or lock
            nxt_cur.err = `FWD_ERR_ABORT;
            nxt_cur.stat = `FWD_STAT_ERR;
            nxt_cur.done = 1'b1;
          end else if (lnk.cmd_feature == `FWD_SUB_ACTIVATE) begin
            // Activation of a held image
            nxt_cur.done = 1'b1;
            if (cur_ff.pending) begin
              nxt_cur.pending = 1'b0;
              if (cur_ff.reload_req && reload_fail) begin
                nxt_cur.err = `FWD_ERR_RELOAD;
                nxt_cur.stat = `FWD_STAT_ERR;
              end else begin
                nxt_cur.activate = 1'b1;
                nxt_cur.spin_down = spinup_disabled;
              end
            end
          end else if (use_ofs != cur_ff.expect_ofs) begin
            // Segment out of sequence: drop all received
            nxt_cur.expect_ofs = 16'h0000;
            nxt_cur.pending = 1'b0;
            nxt_cur.discard = 1'b1;
            nxt_cur.err = `FWD_ERR_ABORT;
            nxt_cur.stat = `FWD_STAT_ERR;
            nxt_cur.done = 1'b1;
          end else if (len_sec == 16'h0000) begin
            nxt_cur.done = 1'b1;
          end else begin
            // Start the data phase
            // Last result stands until this command ends
            nxt_cur.err = cur_ff.err;
            nxt_cur.stat = cur_ff.stat;
            nxt_cur.state = fwd_pkg::FWD_DATA;
            nxt_cur.cmd_ready = 1'b0;
            nxt_cur.dma_ready = 1'b1;
            nxt_cur.words = sec_to_words(len_sec);
            nxt_cur.waddr = sec_to_words(use_ofs);
            nxt_cur.expect_ofs = use_ofs + len_sec;
            if (use_ofs == 16'h0000) begin
              nxt_cur.pending = 1'b0;
            end
          end
        end
      end
      fwd_pkg::FWD_DATA: begin
        nxt_cur.cmd_ready = 1'b0;
        if (take_word) begin
          nxt_cur.wr_valid = 1'b1;
          nxt_cur.wr_addr = cur_ff.waddr;
          nxt_cur.wr_data = lnk.dma_data;
          nxt_cur.waddr = cur_ff.waddr + 23'h000001;
          nxt_cur.words = cur_ff.words - 23'h000001;
          nxt_cur.total = tot;
          if (cur_ff.waddr == 23'h000000) begin
            nxt_cur.reload_req = lnk.dma_data[`FWD_HDR_RELOAD_BIT];
          end
          if (cur_ff.words == 23'h000001) begin
            nxt_cur.dma_ready = 1'b0;
            if (cur_ff.feat == `FWD_SUB_SAVE || cur_ff.expect_ofs >= tot) begin
              nxt_cur.state = fwd_pkg::FWD_VERIFY;
            end else begin
              nxt_cur.state = fwd_pkg::FWD_IDLE;
              nxt_cur.cmd_ready = 1'b1;
              nxt_cur.done = 1'b1;
              nxt_cur.err = 8'h00;
              nxt_cur.stat = `FWD_STAT_OK;
            end
          end
        end
      end
      fwd_pkg::FWD_VERIFY: begin
        // Verify and store the whole image
        nxt_cur.commit = 1'b1;
        nxt_cur.err = 8'h00;
        nxt_cur.stat = `FWD_STAT_OK;
        nxt_cur.expect_ofs = 16'h0000;
        nxt_cur.state = fwd_pkg::FWD_IDLE;
        nxt_cur.cmd_ready = 1'b1;
        nxt_cur.done = 1'b1;
        if (cur_ff.feat == `FWD_SUB_OFS_DEFER) begin
          nxt_cur.pending = 1'b1;
        end else if (cur_ff.reload_req && reload_fail) begin
          nxt_cur.err = `FWD_ERR_RELOAD;
          nxt_cur.stat = `FWD_STAT_ERR;
        end else begin
          nxt_cur.activate = 1'b1;
          nxt_cur.spin_down = spinup_disabled && cur_ff.reload_req;
        end
      end
      default: begin
        nxt_cur.state = fwd_pkg::FWD_IDLE;
      end
    endcase
  end

  // Reset clears received segments and held image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign lnk.cmd_ready = cur_ff.cmd_ready;
  assign lnk.dma_ready = cur_ff.dma_ready;
  assign lnk.done = cur_ff.done;
  assign lnk.err_reg = cur_ff.err;
  assign lnk.stat_reg = cur_ff.stat;
  assign img_wr_valid = cur_ff.wr_valid;
  assign img_wr_addr = cur_ff.wr_addr;
  assign img_wr_data = cur_ff.wr_data;
  assign img_commit = cur_ff.commit;
  assign img_discard = cur_ff.discard;
  assign img_pending = cur_ff.pending;
  assign fw_activate = cur_ff.activate;
  assign spin_down = cur_ff.spin_down;
endmodule : fwd_dev

// >>> fwd_props.sv
// Assertions on the link between host and device ends
`timescale 1ns/1ps
module fwd_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Link
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_seccnt,
  input wire logic [7:0] cmd_secnum,
  input wire logic       dma_valid,
  input wire logic       dma_ready,
  input wire logic       done,
  input wire logic [7:0] err_reg,
  input wire logic [7:0] stat_reg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc;
  logic        op_ok;
  logic        sub_ok;
  logic [15:0] len_ff;
  logic [22:0] wcnt_ff;
  assign acc    = cmd_valid && cmd_ready;
  assign op_ok  = cmd_opcode == 8'h93;
  assign sub_ok = cmd_feature inside {8'h03, 8'h07, 8'h0E, 8'h0F};
  // Length and words taken for the current command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_ff  <= 16'h0000;
      wcnt_ff <= 23'h000000;
    end else if (acc) begin
      len_ff  <= {cmd_secnum, cmd_seccnt};
      wcnt_ff <= 23'h000000;
    end else if (dma_valid && dma_ready) begin
      wcnt_ff <= wcnt_ff + 23'h000001;
    end
  end
  property p_bad_op; acc && !op_ok |=> done && stat_reg == 8'h51 && err_reg[2]; endproperty
  a_bad_op: assert property (p_bad_op) else $error("foreign opcode not aborted");
  property p_bad_sub; acc && op_ok && !sub_ok |=> done && err_reg[2]; endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("reserved code not aborted");
  property p_zero; acc && op_ok && {cmd_secnum, cmd_seccnt} == 16'h0000 |=> done; endproperty
  a_zero: assert property (p_zero) else $error("empty command moved data");
  property p_busy; dma_ready |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("command taken in data phase");
  property p_words; $fell(dma_ready) |-> wcnt_ff == {len_ff, 7'h00}; endproperty
  a_words: assert property (p_words) else $error("word count differs from length");
  property p_end; $fell(dma_ready) |-> ##[0:1] done; endproperty
  a_end: assert property (p_end) else $error("no completion after data");
  property p_stat; done |-> (stat_reg == 8'h50 && err_reg == 8'h00) || (stat_reg == 8'h51 && err_reg != 8'h00); endproperty
  a_stat: assert property (p_stat) else $error("status and error disagree");
  property p_hold; !done |-> $stable(err_reg) && $stable(stat_reg); endproperty
  a_hold: assert property (p_hold) else $error("result changed between commands");
endmodule : fwd_props

// >>> tb_firmware_download_dma_handler.sv
// Bench for the download handler, host and device ends joined
`timescale 1ns/1ps
module tb_firmware_download_dma_handler;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st, img_wr_data, last_data;
  logic        security_locked, spinup_disabled, reload_fail;
  logic        img_wr_valid, img_commit, img_discard, img_pending, fw_activate, spin_down;
  logic [22:0] img_wr_addr, last_addr;
  logic [7:0]  bad [3] = '{8'h00, 8'h08, 8'hFF};
  int          error_cnt, total_checks, n[5], b[5];
  fwd_if lnk ();
  fwd_host fwd_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .lnk(lnk.host));
  fwd_dev fwd_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .security_locked(security_locked),
    .spinup_disabled(spinup_disabled), .reload_fail(reload_fail), .img_wr_valid(img_wr_valid),
    .img_wr_addr(img_wr_addr), .img_wr_data(img_wr_data), .img_commit(img_commit), .img_discard(img_discard),
    .img_pending(img_pending), .fw_activate(fw_activate), .spin_down(spin_down));
  fwd_props fwd_props_inst (.pclk(pclk), .presetn(presetn), .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready),
    .cmd_opcode(lnk.cmd_opcode), .cmd_feature(lnk.cmd_feature), .cmd_seccnt(lnk.cmd_seccnt),
    .cmd_secnum(lnk.cmd_secnum), .dma_valid(lnk.dma_valid), .dma_ready(lnk.dma_ready), .done(lnk.done),
    .err_reg(lnk.err_reg), .stat_reg(lnk.stat_reg));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Event counters on the image store and firmware control outputs
  always @(posedge pclk) begin
    n[0] += img_commit;
    n[1] += fw_activate;
    n[2] += spin_down;
    n[3] += img_discard;
    n[4] += img_wr_valid;
    if (img_wr_valid === 1'b1) begin
      last_addr = img_wr_addr;
      last_data = img_wr_data;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [7:0] op, input logic [7:0] sub, input logic [15:0] cnt, input logic [15:0] ofs);
    apb(1'b1, 8'h04, {16'h0000, ofs});
    apb(1'b1, 8'h08, {16'h0000, cnt});
    apb(1'b1, 8'h00, {16'h0000, op, sub});
  endtask : cmd
  // Poll until done, then compare status and error bytes
  task fin(input logic [15:0] es);
    st = 32'h00000000;
    while (st[1] !== 1'b1) apb(1'b0, 8'h10, 32'h00000000);
    chk({16'h0000, st[23:8]}, {16'h0000, es});
  endtask : fin
  // One segment: whole sectors, header in the first word
  task seg(input logic [7:0] sub, input logic [15:0] ofs, input logic [31:0] hdr, input logic [15:0] es);
    cmd(8'h93, sub, 16'h0001, ofs);
    for (int i = 0; i < 128; i++) apb(1'b1, 8'h0C, (i == 0) ? hdr : 32'(i));
    fin(es);
  endtask : seg
  task ev(input int c, input int a, input int s, input int d, input int w);
    chk(32'(n[0] - b[0]), 32'(c));
    chk(32'(n[1] - b[1]), 32'(a));
    chk(32'(n[2] - b[2]), 32'(s));
    chk(32'(n[3] - b[3]), 32'(d));
    chk(32'(n[4] - b[4]), 32'(w));
    b = n;
  endtask : ev
  task rst;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst
  task end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {security_locked, spinup_disabled, reload_fail} = 3'h0;
    error_cnt = 0;
    total_checks = 0;
    n = '{default: 0};
    b = n;
    rst();
    apb(1'b0, 8'h20, 32'h00000000);
    chk({st[30:0], se}, 32'h00000001);
    cmd(8'h92, 8'h07, 16'h0001, 16'h0000);
    fin(16'h5104);
    foreach (bad[i]) begin
      cmd(8'h93, bad[i], 16'h0001, 16'h0000);
      fin(16'h5104);
    end
    security_locked <= 1'b1;
    cmd(8'h93, 8'h07, 16'h0001, 16'h0000);
    fin(16'h5104);
    security_locked <= 1'b0;
    cmd(8'h93, 8'h07, 16'h0000, 16'h0000);
    fin(16'h5000);
    ev(0, 0, 0, 0, 0);
    $display("test aborts done");
    reload_fail     <= 1'b1;
    spinup_disabled <= 1'b1;
    seg(8'h07, 16'h0005, 32'h00000001, 16'h5000);
    ev(1, 1, 0, 0, 128);
    chk(32'(last_addr), 32'h0000007F);
    chk(last_data, 32'h0000007F);
    seg(8'h07, 16'h0000, 32'h00010001, 16'h5140);
    $display("test save done");
    reload_fail <= 1'b0;
    b = n;
    seg(8'h0E, 16'h0000, 32'h00000002, 16'h5000);
    ev(0, 0, 0, 0, 128);
    seg(8'h0E, 16'h0001, 32'h00000080, 16'h5000);
    ev(1, 0, 0, 0, 128);
    chk(32'(last_addr), 32'h000000FF);
    chk(32'(img_pending), 32'h00000001);
    rst();
    chk(32'(img_pending), 32'h00000000);
    cmd(8'h93, 8'h0F, 16'h0000, 16'h0000);
    fin(16'h5000);
    b = n;
    seg(8'h0E, 16'h0000, 32'h00000002, 16'h5000);
    seg(8'h0E, 16'h0001, 32'h00000080, 16'h5000);
    cmd(8'h93, 8'h0F, 16'h0000, 16'h0000);
    fin(16'h5000);
    ev(1, 1, 1, 0, 256);
    chk(32'(img_pending), 32'h00000000);
    reload_fail <= 1'b1;
    seg(8'h0E, 16'h0000, 32'h00010002, 16'h5000);
    seg(8'h0E, 16'h0001, 32'h00000080, 16'h5000);
    cmd(8'h93, 8'h0F, 16'h0000, 16'h0000);
    fin(16'h5140);
    ev(1, 0, 0, 0, 256);
    reload_fail <= 1'b0;
    $display("test deferred done");
    seg(8'h03, 16'h0000, 32'h00000003, 16'h5000);
    rst();
    cmd(8'h93, 8'h03, 16'h0001, 16'h0001);
    fin(16'h5104);
    seg(8'h03, 16'h0000, 32'h00000003, 16'h5000);
    cmd(8'h93, 8'h03, 16'h0001, 16'h0002);
    fin(16'h5104);
    ev(0, 0, 0, 2, 256);
    $display("test sequence done");
    end_of_test();
  end
endmodule : tb_firmware_download_dma_handler
